// File: pkg/timer_cc_pkg.sv
// constants for the timer compare, capture and pulse accumulator block
package timer_cc_pkg;
	// register indices; byte address is four times the index
	localparam logic [13:0] IDX_MASTER_MASK   = 14'h100C;
	localparam logic [13:0] IDX_MASTER_DATA   = 14'h100D;
	localparam logic [13:0] IDX_ACTION_CTRL   = 14'h1020;
	localparam logic [13:0] IDX_EDGE_CTRL     = 14'h1021;
	localparam logic [13:0] IDX_CHAN_ENABLES  = 14'h1022;
	localparam logic [13:0] IDX_CHAN_FLAGS    = 14'h1023;
	localparam logic [13:0] IDX_MISC_ENABLES  = 14'h1024;
	localparam logic [13:0] IDX_MISC_FLAGS    = 14'h1025;
	localparam logic [13:0] IDX_ACCUM_CONTROL = 14'h1026;
	localparam logic [13:0] IDX_ACCUM_COUNT   = 14'h1027;

	localparam logic [7:0] RESET_BYTE  = 8'h00;
	localparam logic [7:0] PORT_BITS   = 8'hF8;
	localparam logic [7:0] MISC_EN_BITS = 8'hF3;
	localparam logic [7:0] MISC_FL_BITS = 8'hF0;

	// accumulator control field positions
	localparam int DDR7_POS  = 7;
	localparam int EN_POS    = 6;
	localparam int MODE_POS  = 5;
	localparam int EDGE_POS  = 4;
	localparam int DDR3_POS  = 3;
	localparam int SEL45_POS = 2;

	// misc flag / enable positions
	localparam int OVF_POS   = 7;
	localparam int PER_POS   = 6;
	localparam int AOVF_POS  = 5;
	localparam int AEDGE_POS = 4;

	// timing
	localparam int E_CLOCK_MHZ      = 100;
	localparam int LOCK_E_CYCLES    = 64;
	localparam int GATE_DIVIDE      = 64;
	localparam int PERIOD_BASE_LOG2 = 13;

	typedef enum logic [1:0] {
		ACT_OFF,
		ACT_TOGGLE,
		ACT_LOW,
		ACT_HIGH
	} action_t;
endpackage

// File: hw/timer_cc.sv
// timer compare/capture control, prescaler, periodic tick, pulse accumulator
//
// Chosen here: register access over APB.
`timescale 1ns/1ps

module timer_cc #(
	parameter int PERIOD_LOG2 = timer_cc_pkg::PERIOD_BASE_LOG2
) (
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [15:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        SPECIAL_MODE,
	input  wire logic        COUNTER_WRAP,
	input  wire logic [4:0]  COMPARE_MATCH,
	input  wire logic [7:0]  PORTA_IN,
	output logic      [7:3]  PORTA_OUT,
	output logic      [7:3]  PORTA_OE,
	output logic             TIMER_TICK,
	output logic             TIMER_IRQ
);
	localparam int LOCK_CYCLES = timer_cc_pkg::LOCK_E_CYCLES;
	localparam int GATE_CYCLES = timer_cc_pkg::GATE_DIVIDE;
	localparam int PER_W = PERIOD_LOG2 + 3;

	logic [7:0] master_mask;
	logic [7:0] master_data;
	logic [7:0] action_ctrl;
	logic [7:0] edge_ctrl;
	logic [7:0] chan_enables;
	logic [7:0] chan_flags;
	logic [7:0] misc_enables;
	logic [7:0] misc_flags;
	logic [7:0] accum_control;
	logic [7:0] accum_count;
	logic       prescale_locked;
	logic [6:0] lock_count;
	logic [3:0] prescale_count;
	logic [PER_W-1:0] period_count;
	logic [5:0] gate_count;
	logic [3:0] cap_prev;
	logic       accum_prev;
	logic [7:3] port_latch;

	function automatic logic edge_hit(input logic [1:0] sel,
		input logic prev, input logic cur);
		edge_hit = (sel[0] & ~prev & cur) | (sel[1] & prev & ~cur);
	endfunction

	function automatic logic at_index(input logic [15:0] addr,
		input logic [13:0] idx);
		at_index = (addr == {idx, 2'b00});
	endfunction

	// bus decode
	wire access    = PSEL & PENABLE;
	wire wr        = access & PREADY & PWRITE;
	wire [7:0] wd  = PWDATA[7:0];
	wire hit_mask  = at_index(PADDR, timer_cc_pkg::IDX_MASTER_MASK);
	wire hit_data  = at_index(PADDR, timer_cc_pkg::IDX_MASTER_DATA);
	wire hit_act   = at_index(PADDR, timer_cc_pkg::IDX_ACTION_CTRL);
	wire hit_edge  = at_index(PADDR, timer_cc_pkg::IDX_EDGE_CTRL);
	wire hit_cen   = at_index(PADDR, timer_cc_pkg::IDX_CHAN_ENABLES);
	wire hit_cfl   = at_index(PADDR, timer_cc_pkg::IDX_CHAN_FLAGS);
	wire hit_men   = at_index(PADDR, timer_cc_pkg::IDX_MISC_ENABLES);
	wire hit_mfl   = at_index(PADDR, timer_cc_pkg::IDX_MISC_FLAGS);
	wire hit_pac   = at_index(PADDR, timer_cc_pkg::IDX_ACCUM_CONTROL);
	wire hit_cnt   = at_index(PADDR, timer_cc_pkg::IDX_ACCUM_COUNT);
	wire mapped    = hit_mask | hit_data | hit_act | hit_edge | hit_cen
		| hit_cfl | hit_men | hit_mfl | hit_pac | hit_cnt;

	wire [7:0] rd_byte =
		({8{hit_mask}} & master_mask)
		| ({8{hit_data}} & master_data)
		| ({8{hit_act}}  & action_ctrl)
		| ({8{hit_edge}} & edge_ctrl)
		| ({8{hit_cen}}  & chan_enables)
		| ({8{hit_cfl}}  & chan_flags)
		| ({8{hit_men}}  & misc_enables)
		| ({8{hit_mfl}}  & misc_flags)
		| ({8{hit_pac}}  & accum_control)
		| ({8{hit_cnt}}  & accum_count);

	// prescale select write permission
	// outside SPECIAL_MODE, locked after first write or 64 cycles
	wire pr_writable = SPECIAL_MODE | ~prescale_locked;
	wire [7:0] men_wmask = timer_cc_pkg::MISC_EN_BITS
		& {6'h3F, {2{pr_writable}}};
	wire [7:0] next_misc_enables = (misc_enables & ~men_wmask)
		| (wd & men_wmask);
	wire lock_done = (lock_count == 7'(LOCK_CYCLES - 1));
	wire next_locked = prescale_locked | lock_done | (wr & hit_men);

	// divide factor 1, 4, 8, 16
	wire [1:0] pr_sel = misc_enables[1:0];
	wire [3:0] pr_mask = (pr_sel == 2'h0) ? 4'h0 :
		(pr_sel == 2'h1) ? 4'h3 :
		(pr_sel == 2'h2) ? 4'h7 : 4'hF;
	wire next_tick = ((prescale_count & pr_mask) == pr_mask);

	// tap from rate bits: period 2^13 cycles at rate 0, (2^13-1)*2^rate+1 cycles above
	wire [1:0] rate = accum_control[1:0];
	wire [PER_W-1:0] per_mask = PER_W'(({3'h0, {PERIOD_LOG2{1'b1}}}
		<< rate) | {PER_W{1'b0}});
	// first flag only after a whole period
	wire period_hit = ((period_count & per_mask) == per_mask);

	// capture channels: index 0..3 = channel 1..4
	wire [3:0] cap_pin = {PORTA_IN[3], PORTA_IN[0], PORTA_IN[1],
		PORTA_IN[2]};
	// edge pairs descend from bit 7
	wire [7:0] cap_sel = {edge_ctrl[7:6], edge_ctrl[1:0],
		edge_ctrl[3:2], edge_ctrl[5:4]};
	wire [3:0] cap_hit;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_cap
			assign cap_hit[gi] = edge_hit(cap_sel[2*gi+1 -: 2],
				cap_prev[gi], cap_pin[gi]);
		end
	endgenerate

	wire sel_capture = accum_control[timer_cc_pkg::SEL45_POS];
	wire shared_set = sel_capture ? cap_hit[3] : COMPARE_MATCH[4];
	wire [7:0] chan_set = {COMPARE_MATCH[0], COMPARE_MATCH[1],
		COMPARE_MATCH[2], COMPARE_MATCH[3], shared_set,
		cap_hit[0], cap_hit[1], cap_hit[2]};
	// write one clears, set wins over clear
	wire [7:0] chan_clr = (wr & hit_cfl) ? wd : 8'h00;
	wire [7:0] next_chan_flags = (chan_flags & ~chan_clr) | chan_set;

	// pulse accumulator
	// pin level feeds accumulator regardless of direction
	wire acc_pin = PORTA_IN[7];
	wire acc_on = accum_control[timer_cc_pkg::EN_POS];
	wire acc_gated = accum_control[timer_cc_pkg::MODE_POS];
	wire acc_pol = accum_control[timer_cc_pkg::EDGE_POS];
	// polarity picks edge or inhibiting level
	wire acc_edge = acc_pol ? (~accum_prev & acc_pin)
		: (accum_prev & ~acc_pin);
	wire gate_tick = (gate_count == 6'(GATE_CYCLES - 1));
	// gated mode counts E/64 while active
	wire acc_inc = acc_on & (acc_gated ? (gate_tick & (acc_pin != acc_pol))
		: acc_edge);
	wire acc_wrap = acc_inc & (accum_count == 8'hFF);
	wire [7:0] next_accum_count = (wr & hit_cnt) ? wd
		: (acc_inc ? accum_count + 8'h01 : accum_count);

	wire [7:0] misc_set = {COUNTER_WRAP, period_hit, acc_wrap,
		acc_on & acc_edge, 4'h0};
	// write one clears, set wins over clear
	wire [7:0] misc_clr = (wr & hit_mfl) ? wd : 8'h00;
	wire [7:0] next_misc_flags = ((misc_flags & ~misc_clr) | misc_set)
		& timer_cc_pkg::MISC_FL_BITS;

	// channel flag with enable requests interrupt
	// upper misc enables gate misc flags
	wire next_irq = (|(chan_flags & chan_enables))
		| (|(misc_flags[7:4] & misc_enables[7:4]));

	// compare output actions on port lines 6..3
	wire [3:0] oc_match = {COMPARE_MATCH[1], COMPARE_MATCH[2],
		COMPARE_MATCH[3], COMPARE_MATCH[4] & ~sel_capture};
	logic [7:3] next_port;
	logic [7:3] oe_action;
	always_comb
	begin
		next_port = port_latch;
		oe_action = 5'h00;
		for (int i = 0; i < 4; i++)
		begin
			// pair i+3 sits at bits 2i+1:2i
			if (action_ctrl[2*i+1 -: 2] != 2'h0 && !(i == 0 && sel_capture))
			begin
				oe_action[i+3] = 1'b1;
			end
			if (oc_match[i])
			begin
				unique case (timer_cc_pkg::action_t'(action_ctrl[2*i+1 -: 2]))
					timer_cc_pkg::ACT_OFF:    next_port[i+3] = port_latch[i+3];
					timer_cc_pkg::ACT_TOGGLE: next_port[i+3] = ~port_latch[i+3];
					timer_cc_pkg::ACT_LOW:    next_port[i+3] = 1'b0;
					timer_cc_pkg::ACT_HIGH:   next_port[i+3] = 1'b1;
				endcase
			end
		end
		// masked master data copied on master match
		// applied last so the master channel prevails
		if (COMPARE_MATCH[0])
		begin
			for (int j = 3; j < 8; j++)
			begin
				if (master_mask[j])
				begin
					next_port[j] = master_data[j];
				end
			end
		end
	end

	wire [7:3] next_oe = {accum_control[timer_cc_pkg::DDR7_POS],
		oe_action[6:4] | master_mask[6:4],
		accum_control[timer_cc_pkg::DDR3_POS] | oe_action[3]};

	// bus answer: one wait state, data and error registered
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h00000000;
			PSLVERR <= 1'b0;
		end
		else
		begin
			PREADY  <= access & ~PREADY;
			PRDATA  <= (access & ~PREADY & ~PWRITE) ? {24'h000000, rd_byte}
				: 32'h00000000;
			PSLVERR <= access & ~PREADY & ~mapped;
		end
	end

	// software registers
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			master_mask   <= timer_cc_pkg::RESET_BYTE;
			master_data   <= timer_cc_pkg::RESET_BYTE;
			action_ctrl   <= timer_cc_pkg::RESET_BYTE;
			edge_ctrl     <= timer_cc_pkg::RESET_BYTE;
			chan_enables  <= timer_cc_pkg::RESET_BYTE;
			misc_enables  <= timer_cc_pkg::RESET_BYTE;
			accum_control <= timer_cc_pkg::RESET_BYTE;
		end
		else if (wr)
		begin
			if (hit_mask)
			begin
				master_mask <= wd & timer_cc_pkg::PORT_BITS;
			end
			if (hit_data)
			begin
				master_data <= wd & timer_cc_pkg::PORT_BITS;
			end
			if (hit_act)
			begin
				action_ctrl <= wd;
			end
			if (hit_edge)
			begin
				edge_ctrl <= wd;
			end
			if (hit_cen)
			begin
				chan_enables <= wd;
			end
			if (hit_men)
			begin
				misc_enables <= next_misc_enables;
			end
			if (hit_pac)
			begin
				accum_control <= wd;
			end
		end
	end

	// status, counters and pins
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			chan_flags      <= timer_cc_pkg::RESET_BYTE;
			misc_flags      <= timer_cc_pkg::RESET_BYTE;
			accum_count     <= timer_cc_pkg::RESET_BYTE;
			prescale_locked <= 1'b0;
			lock_count      <= 7'h00;
			prescale_count  <= 4'h0;
			period_count    <= '0;
			gate_count      <= 6'h00;
			cap_prev        <= 4'h0;
			accum_prev      <= 1'b0;
			port_latch      <= 5'h00;
			PORTA_OUT       <= 5'h00;
			PORTA_OE        <= 5'h00;
			TIMER_TICK      <= 1'b0;
			TIMER_IRQ       <= 1'b0;
		end
		else
		begin
			chan_flags      <= next_chan_flags;
			misc_flags      <= next_misc_flags;
			accum_count     <= next_accum_count;
			prescale_locked <= next_locked;
			lock_count      <= lock_done ? lock_count : lock_count + 7'h01;
			prescale_count  <= prescale_count + 4'h1;
			// periodic divider restarts when its tap fires
			period_count    <= period_hit ? '0 : period_count + 1'b1;
			gate_count      <= gate_count + 6'h01;
			cap_prev        <= cap_pin;
			accum_prev      <= acc_pin;
			port_latch      <= next_port;
			PORTA_OUT       <= next_port;
			PORTA_OE        <= next_oe;
			TIMER_TICK      <= next_tick;
			TIMER_IRQ       <= next_irq;
		end
	end
endmodule // timer_cc

// File: testbench/timer_cc_chk.sv
// port-level assertions for the timer block
`timescale 1ns/1ps
module timer_cc_chk (
	input wire logic        CLK,
	input wire logic        RST_B,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [15:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic [4:0]  COMPARE_MATCH,
	input wire logic [7:3]  PORTA_OUT,
	input wire logic [7:3]  PORTA_OE,
	input wire logic        TIMER_TICK
);
	wire [13:0] idx = PADDR[15:2];
	wire mapped = PADDR[1:0] == 2'h0 &&
		(idx == timer_cc_pkg::IDX_MASTER_MASK ||
		idx == timer_cc_pkg::IDX_MASTER_DATA ||
		(idx >= timer_cc_pkg::IDX_ACTION_CTRL &&
		idx <= timer_cc_pkg::IDX_ACCUM_COUNT));
	wire wr_done = PREADY && PWRITE;
	wire any_match = |COMPARE_MATCH;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	rdata_high_a: assert property (PRDATA[31:8] == 24'h0)
		else $error("upper read data not zero");
	rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
		else $error("read data outside ready cycle");
	error_pair_a: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	ready_wait_a: assert property (PSEL && $rose(PENABLE) |=> PREADY)
		else $error("ready not one cycle after access");
	ready_once_a: assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	decode_err_a: assert property (PREADY |-> PSLVERR == !mapped)
		else $error("error flag disagrees with address map");
	port_cause_a: assert property ($changed(PORTA_OUT) |->
		$past(any_match)) else $error("port moved without compare");
	oe_cause_a: assert property ($changed(PORTA_OE) |->
		$past(wr_done) || $past(wr_done, 2))
		else $error("enable moved without write");
	tick_gap_a: assert property (TIMER_TICK |=> ##[0:15] TIMER_TICK)
		else $error("prescaled tick gap over sixteen");
endmodule // timer_cc_chk

bind timer_cc timer_cc_chk u_timer_cc_chk (.CLK(CLK), .RST_B(RST_B),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.COMPARE_MATCH(COMPARE_MATCH), .PORTA_OUT(PORTA_OUT),
	.PORTA_OE(PORTA_OE), .TIMER_TICK(TIMER_TICK));

// File: testbench/porta_pins.sv
// port A pin model: driven lines override external levels
`timescale 1ns/1ps
module porta_pins (
	input wire logic [7:0] ext,
	input wire logic [7:3] out,
	input wire logic [7:3] oe,
	output logic     [7:0] pin
);
	// a driven line 7 still reaches the accumulator
	assign pin = {(oe & out) | (~oe & ext[7:3]), ext[2:0]};
endmodule // porta_pins

// File: testbench/timer_cc_tb.sv
// self-checking bench for the timer block
`timescale 1ns/1ps
module timer_cc_tb;
	logic clk, rst_b, psel, penable, pwrite, spec, wrap, pready, slverr;
	logic tick, irq, e;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [4:0] cm;
	logic [7:0] ext, pin, r;
	logic [7:3] pout, poe;
	int fails, compares, n;
	int dv[4] = '{1, 4, 8, 16};
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	timer_cc #(.PERIOD_LOG2(4)) u_timer_cc (.CLK(clk), .RST_B(rst_b),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(slverr), .SPECIAL_MODE(spec), .COUNTER_WRAP(wrap),
		.COMPARE_MATCH(cm), .PORTA_IN(pin), .PORTA_OUT(pout),
		.PORTA_OE(poe), .TIMER_TICK(tick), .TIMER_IRQ(irq));
	porta_pins u_porta_pins (.ext(ext), .out(pout), .oe(poe), .pin(pin));
	task automatic wrap_up;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(string s, logic [7:0] x, logic [7:0] g);
		compares++;
		if (g !== x)
		begin
			fails++;
			$display("mismatch %s exp %h got %h", s, x, g);
		end
	endtask
	task automatic apb(logic w, logic [13:0] i, logic [7:0] d);
		int k;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		r = prdata[7:0];
		e = slverr;
		psel <= 0;
		penable <= 0;
		if (k >= 20)
		begin
			fails++;
			wrap_up;
		end
	endtask
	task automatic wr(logic [13:0] i, logic [7:0] d);
		apb(1, i, d);
	endtask
	task automatic rd(string s, logic [13:0] i, logic [7:0] x, logic [7:0] m);
		apb(0, i, 8'h00);
		chk(s, x, r & m);
	endtask
	task automatic pulse(logic [4:0] v);
		@(posedge clk);
		cm <= v;
		@(posedge clk);
		cm <= 0;
		repeat (3) @(posedge clk);
	endtask
	initial
	begin
		{rst_b, psel, penable, pwrite, spec, wrap, cm, ext} = 0;
		paddr = 0;
		pwdata = 0;
		repeat (4) @(posedge clk);
		rst_b <= 1;
		wr(timer_cc_pkg::IDX_MISC_ENABLES, 8'hFF);
		rd("misc en", timer_cc_pkg::IDX_MISC_ENABLES, 8'hF3, 8'hFF);
		wr(timer_cc_pkg::IDX_MISC_ENABLES, 8'h00);
		rd("locked", timer_cc_pkg::IDX_MISC_ENABLES, 8'h03, 8'hFF);
		for (int i = 0; i < 8; i++)
			rd("reset", timer_cc_pkg::IDX_MASTER_DATA + 14'(i), 0, 8'hFF);
		apb(0, 14'h1000, 8'h00);
		chk("unmapped err", 8'h01, {7'h0, e});
		chk("unmapped data", 8'h00, r);
		spec <= 1;
		for (int p = 0; p < 4; p++)
		begin
			wr(timer_cc_pkg::IDX_MISC_ENABLES, 8'(p));
			repeat (4) @(posedge clk);
			n = 0;
			repeat (64) @(posedge clk) n += tick;
			chk("ticks", 8'(64 / dv[p]), 8'(n));
		end
		spec <= 0;
		wr(timer_cc_pkg::IDX_MASTER_DATA, 8'hFF);
		rd("mdata", timer_cc_pkg::IDX_MASTER_DATA, 8'hF8, 8'hFF);
		wr(timer_cc_pkg::IDX_ACTION_CTRL, 8'hFF);
		pulse(5'h1E);
		chk("port high", 8'h78, {pout, 3'h0});
		wr(timer_cc_pkg::IDX_ACTION_CTRL, 8'h6C);
		pulse(5'h1E);
		chk("port mix", 8'h18, {pout, 3'h0});
		chk("port oe", 8'h70, {poe, 3'h0});
		rd("cflags", timer_cc_pkg::IDX_CHAN_FLAGS, 8'h78, 8'hFF);
		wr(timer_cc_pkg::IDX_CHAN_FLAGS, 8'h00);
		rd("w0", timer_cc_pkg::IDX_CHAN_FLAGS, 8'h78, 8'hFF);
		wr(timer_cc_pkg::IDX_CHAN_FLAGS, 8'h40);
		rd("w1", timer_cc_pkg::IDX_CHAN_FLAGS, 8'h38, 8'hFF);
		wr(timer_cc_pkg::IDX_MASTER_MASK, 8'hF8);
		wr(timer_cc_pkg::IDX_MASTER_DATA, 8'hA8);
		pulse(5'h1F);
		chk("master", 8'hA8, {pout, 3'h0});
		chk("irq off", 8'h00, 8'(irq));
		wr(timer_cc_pkg::IDX_CHAN_ENABLES, 8'h80);
		repeat (3) @(posedge clk);
		chk("irq on", 8'h01, 8'(irq));
		wr(timer_cc_pkg::IDX_CHAN_FLAGS, 8'h80);
		repeat (3) @(posedge clk);
		chk("irq clr", 8'h00, 8'(irq));
		wr(timer_cc_pkg::IDX_EDGE_CTRL, 8'h10);
		wr(timer_cc_pkg::IDX_CHAN_FLAGS, 8'hFF);
		ext[2] <= 1;
		rd("rise", timer_cc_pkg::IDX_CHAN_FLAGS, 8'h04, 8'hFF);
		wr(timer_cc_pkg::IDX_CHAN_FLAGS, 8'hFF);
		ext[2] <= 0;
		rd("fall", timer_cc_pkg::IDX_CHAN_FLAGS, 8'h00, 8'hFF);
		@(posedge clk);
		wrap <= 1;
		@(posedge clk);
		wrap <= 0;
		rd("ovf", timer_cc_pkg::IDX_MISC_FLAGS, 8'h80, 8'h8F);
		wr(timer_cc_pkg::IDX_MISC_FLAGS, 8'hC0);
		rd("ovf clr", timer_cc_pkg::IDX_MISC_FLAGS, 8'h00, 8'h80);
		repeat (40) @(posedge clk);
		rd("periodic", timer_cc_pkg::IDX_MISC_FLAGS, 8'h40, 8'h40);
		wr(timer_cc_pkg::IDX_ACCUM_CONTROL, 8'h50);
		wr(timer_cc_pkg::IDX_ACCUM_COUNT, 8'hFE);
		wr(timer_cc_pkg::IDX_MISC_FLAGS, 8'h30);
		// edges at half the clock rate, the fastest allowed
		repeat (3)
		begin
			@(posedge clk) ext[7] <= 1;
			@(posedge clk) ext[7] <= 0;
		end
		rd("events", timer_cc_pkg::IDX_ACCUM_COUNT, 8'h01, 8'hFF);
		rd("acc flags", timer_cc_pkg::IDX_MISC_FLAGS, 8'h30, 8'h30);
		wr(timer_cc_pkg::IDX_ACCUM_CONTROL, 8'h60);
		ext[7] <= 1;
		wr(timer_cc_pkg::IDX_ACCUM_COUNT, 8'h00);
		repeat (130) @(posedge clk);
		rd("gated", timer_cc_pkg::IDX_ACCUM_COUNT, 8'h00, 8'hFC);
		chk("gated", 8'h01, 8'(r >= 2 && r <= 3));
		ext[7] <= 0;
		wr(timer_cc_pkg::IDX_ACCUM_COUNT, 8'h00);
		repeat (130) @(posedge clk);
		rd("inhibit", timer_cc_pkg::IDX_ACCUM_COUNT, 8'h00, 8'hFF);
		wr(timer_cc_pkg::IDX_MASTER_DATA, 8'h00);
		wr(timer_cc_pkg::IDX_ACCUM_CONTROL, 8'hD0);
		pulse(5'h01);
		wr(timer_cc_pkg::IDX_ACCUM_COUNT, 8'h00);
		wr(timer_cc_pkg::IDX_MASTER_DATA, 8'h80);
		pulse(5'h01);
		rd("line7", timer_cc_pkg::IDX_ACCUM_COUNT, 8'h01, 8'hFF);
		// second reset: prescale lock by time alone, shared bit as capture
		rst_b <= 0;
		repeat (4) @(posedge clk);
		rst_b <= 1;
		rd("flags2", timer_cc_pkg::IDX_MISC_FLAGS, 8'h00, 8'hFF);
		for (int i = 0; i < 8; i++)
		begin
			// periodic flag may already be up when its register is read
			r = (i == 5) ? 8'hBF : 8'hFF;
			rd("reset2", timer_cc_pkg::IDX_ACTION_CTRL + 14'(i), 8'h00, r);
		end
		repeat (70) @(posedge clk);
		wr(timer_cc_pkg::IDX_MISC_ENABLES, 8'h03);
		rd("time lock", timer_cc_pkg::IDX_MISC_ENABLES, 8'h00, 8'hFF);
		wr(timer_cc_pkg::IDX_ACCUM_CONTROL, 8'h04);
		wr(timer_cc_pkg::IDX_EDGE_CTRL, 8'hC0);
		pulse(5'h10);
		rd("ch5 off", timer_cc_pkg::IDX_CHAN_FLAGS, 8'h00, 8'hFF);
		ext[3] <= 1;
		rd("capture4", timer_cc_pkg::IDX_CHAN_FLAGS, 8'h08, 8'hFF);
		wr(timer_cc_pkg::IDX_MISC_ENABLES, 8'h80);
		@(posedge clk);
		wrap <= 1;
		@(posedge clk);
		wrap <= 0;
		repeat (3) @(posedge clk);
		chk("misc irq", 8'h01, 8'(irq));
		wr(timer_cc_pkg::IDX_MISC_FLAGS, 8'h80);
		repeat (3) @(posedge clk);
		chk("misc irq clr", 8'h00, 8'(irq));
		wrap_up;
	end
endmodule // timer_cc_tb
